// [dv/bus_host.sv]
// host bus controller model driving the multiplexed address/data port
`default_nettype none
module bus_host (
	input  wire logic                 mclk,
	input  wire logic [7:0]           devData,
	input  wire logic                 devOe_n,
	output var muxed_port_pkg::bus_pins_t pins
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       addrStb = 1'b0;
	logic       dataStb = 1'b0;
	logic       rdWr = 1'b1;
	logic       chipSel_n = 1'b0;
	logic       drv = 1'b0;
	logic [7:0] dv = 8'h00;
	logic [7:0] lastVal = 8'h00;
	logic [7:0] bus;
	// a released bus shows the inverse of its last level, never a held value
	always_comb bus = !devOe_n ? devData : (drv ? dv : ~lastVal);
	always_ff @(posedge mclk) lastVal <= bus;
	always_comb pins = '{addrStb, dataStb, rdWr, chipSel_n, bus};
	task automatic hold(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// every data phase is preceded by its own address phase
	task automatic addr_phase(input logic [6:0] a);
		hold(1);
		addrStb = 1'b1;
		drv = 1'b1;
		dv = {1'b0, a};
		hold(6);
		addrStb = 1'b0;
		hold(6);
		drv = 1'b0;
	endtask
	task automatic write_data(input logic bus_style_select, input logic [7:0] d);
		drv = 1'b1;
		dv = d;
		if (bus_style_select) dataStb = 1'b1;
		rdWr = 1'b0;
		hold(6);
		if (bus_style_select) dataStb = 1'b0;
		else rdWr = 1'b1;
		hold(6);
		drv = 1'b0;
		rdWr = 1'b1;
	endtask
	task automatic read_data(input logic bus_style_select, output logic [7:0] d, output logic drove);
		d = 8'h00;
		drove = 1'b0;
		dataStb = bus_style_select;
		repeat (9) begin
			@(posedge mclk);
			#1;
			if (devOe_n === 1'b0) begin
				drove = 1'b1;
				d = devData;
			end
		end
		@(negedge mclk);
		dataStb = !bus_style_select;
		hold(6);
	endtask
endmodule
`default_nettype wire

// [dv/test_muxed_bus_port.sv]
// self-checking bench for the multiplexed bus port
`default_nettype none
module test_muxed_bus_port;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PU = 40;
	logic mclk = 0, rst_n = 0, supplyValid = 1, style = 1, sqEn = 0, drove;
	logic en = 1, osc = 1, chRst = 0;
	logic [3:0] rateSel = 4'h0;
	logic [7:0] devData, rdByte;
	logic devOe_n, sqOut, sqOe_n, tick, ready;
	muxed_port_pkg::bus_pins_t pins;
	int fail_count = 0, n_tests = 0;
	always #25 mclk = ~mclk;
	bus_host u_bus_host (.mclk(mclk), .devData(devData), .devOe_n(devOe_n), .pins(pins));
	muxed_bus_port #(.POWERUP_CYCLES(PU)) u_muxed_bus_port (.mclk(mclk), .rst_n(rst_n), .clkEn(en),
		.supplyValid(supplyValid), .oscRunning(osc), .chainReset(chRst), .busStyleSelect(style),
		.addressLatchStrobe(pins.addrStb), .dataStrobe(pins.dataStb), .readWrite(pins.rdWr),
		.chipSel_n(pins.chipSel_n), .muxedLineBusIn(pins.muxedIn), .rateSelect(rateSel),
		.squareWaveEnable(sqEn), .muxedLineBusOut(devData), .muxedLineBusOe_n(devOe_n),
		.squareWaveOut(sqOut), .squareWaveOe_n(sqOe_n), .periodicTick(tick), .accessReady(ready));
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp, input string what);
		check_byte({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic check_count(input int got, input int lo, input int hi, input string what);
		n_tests++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("Error at %0t: %s count %0d", $time, what, got);
		end
	endtask
	task automatic wait_ready(output int n);
		n = 0;
		while (ready !== 1'b1) begin
			@(negedge mclk);
			n++;
			if (n > 4 * PU) begin
				fail_count++;
				$display("Error at %0t: ready timeout", $time);
				end_of_test();
			end
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		u_bus_host.addr_phase(a);
		u_bus_host.write_data(style, d);
	endtask
	task automatic rd(input logic [6:0] a);
		u_bus_host.addr_phase(a);
		u_bus_host.read_data(style, rdByte, drove);
	endtask
	task automatic measure(input logic [3:0] code, input logic en, output int nt, output int ns);
		logic last;
		rateSel = code;
		sqEn = en;
		nt = 0;
		ns = 0;
		u_bus_host.hold(50);
		last = sqOut;
		repeat (10000) begin
			@(negedge mclk);
			nt += (tick === 1'b1);
			ns += (sqOut === 1'b1 && last === 1'b0);
			last = sqOut;
		end
	endtask
	task automatic test_powerup();
		int n;
		wr(7'h10, 8'h5A);
		check_bit(ready, 1'b0, "ready early");
		wait_ready(n);
		rd(7'h10);
		check_bit(rdByte === 8'h5A, 1'b0, "write before ready");
		$display("test powerup done");
	endtask
	task automatic test_strobe();
		logic [6:0] addrs [6] = '{7'h00, 7'h0D, 7'h0E, 7'h3F, 7'h40, 7'h7F};
		foreach (addrs[i]) wr(addrs[i], {1'b1, addrs[i]} ^ 8'h5A);
		foreach (addrs[i]) begin
			rd(addrs[i]);
			check_byte(rdByte, {1'b1, addrs[i]} ^ 8'h5A, "strobe read");
			check_bit(devOe_n, 1'b1, "strobe release");
		end
		$display("test strobe done");
	endtask
	task automatic test_separate();
		// deselect while the style flips so no stray strobe edge is taken as an access
		u_bus_host.chipSel_n = 1'b1;
		style = 1'b0;
		u_bus_host.dataStb = 1'b1;
		u_bus_host.hold(6);
		u_bus_host.chipSel_n = 1'b0;
		wr(7'h21, 8'hC3);
		rd(7'h21);
		check_byte(rdByte, 8'hC3, "separate read");
		check_bit(devOe_n, 1'b1, "separate release");
		rd(7'h7F);
		check_byte(rdByte, 8'hA5, "separate old byte");
		u_bus_host.chipSel_n = 1'b1;
		style = 1'b1;
		u_bus_host.dataStb = 1'b0;
		u_bus_host.hold(6);
		u_bus_host.chipSel_n = 1'b0;
		$display("test separate done");
	endtask
	task automatic test_chipsel();
		u_bus_host.chipSel_n = 1'b1;
		wr(7'h0E, 8'h00);
		rd(7'h0E);
		check_bit(drove, 1'b0, "deselected drive");
		u_bus_host.chipSel_n = 1'b0;
		rd(7'h0E);
		check_byte(rdByte, 8'hD4, "deselected write");
		$display("test chipsel done");
	endtask
	task automatic test_addr_clear();
		u_bus_host.addr_phase(7'h0D);
		u_bus_host.chipSel_n = 1'b1;
		u_bus_host.addrStb = 1'b1;
		u_bus_host.hold(6);
		u_bus_host.chipSel_n = 1'b0;
		u_bus_host.read_data(style, rdByte, drove);
		check_bit(drove, 1'b0, "cleared address");
		u_bus_host.addrStb = 1'b0;
		u_bus_host.hold(6);
		$display("test addr clear done");
	endtask
	task automatic test_supply();
		int nt, ns;
		supplyValid = 1'b0;
		wr(7'h00, 8'h33);
		rd(7'h00);
		check_bit(drove, 1'b0, "low supply drive");
		measure(4'h3, 1'b1, nt, ns);
		check_count(nt, 4, 5, "low supply ticks");
		check_count(ns, 0, 0, "low supply square");
		check_bit(sqOe_n, 1'b1, "square float");
		supplyValid = 1'b1;
		wait_ready(nt);
		check_count(nt, PU, PU + 5, "hold-off");
		rd(7'h00);
		check_byte(rdByte, 8'hDA, "protected byte");
		$display("test supply done");
	endtask
	task automatic test_gate();
		int n, nt, ns;
		osc = 1'b0;
		u_bus_host.hold(2);
		check_bit(ready, 1'b0, "osc stall ready");
		osc = 1'b1;
		wait_ready(n);
		check_count(n, PU, PU + 5, "osc hold-off");
		chRst = 1'b1;
		u_bus_host.hold(2);
		check_bit(ready, 1'b0, "chain reset ready");
		measure(4'h3, 1'b1, nt, ns);
		check_count(nt + ns, 0, 0, "chain held silent");
		chRst = 1'b0;
		wait_ready(n);
		check_count(n, PU, PU + 5, "chain hold-off");
		// a frozen port must not see the strobes at all
		en = 1'b0;
		wr(7'h0D, 8'h11);
		en = 1'b1;
		u_bus_host.hold(4);
		rd(7'h0D);
		check_byte(rdByte, 8'hD7, "frozen write");
		$display("test gate done");
	endtask
	task automatic test_rate();
		int nt, ns;
		measure(4'h3, 1'b1, nt, ns);
		check_count(nt, 4, 5, "code 3 ticks");
		check_count(ns, 4, 5, "code 3 square");
		check_bit(sqOe_n, 1'b0, "square driven");
		measure(4'h4, 1'b1, nt, ns);
		check_count(ns, 2, 3, "code 4 square");
		measure(4'h0, 1'b1, nt, ns);
		check_count(nt + ns, 0, 0, "code 0 silent");
		measure(4'h3, 1'b0, nt, ns);
		check_count(nt, 4, 5, "gated ticks");
		check_count(ns, 0, 0, "gated square");
		$display("test rate done");
	endtask
	initial begin
		repeat (10) @(negedge mclk);
		rst_n = 1'b1;
		test_powerup();
		test_strobe();
		test_separate();
		test_chipsel();
		test_addr_clear();
		test_supply();
		test_gate();
		test_rate();
		end_of_test();
	end
endmodule
`default_nettype wire

// [rtl/muxed_bus_port.sv]
// multiplexed address/data port with power-up gating and square wave output
`default_nettype none
module muxed_bus_port #(
	parameter int POWERUP_CYCLES = muxed_port_pkg::POWERUP_CYCLES,
	parameter int MEM_BYTES      = muxed_port_pkg::MEM_BYTES
) (
	input  wire logic                      mclk,
	input  wire logic                      rst_n,
	input  wire logic                      clkEn,
	input  wire logic                      supplyValid,
	input  wire logic                      oscRunning,
	input  wire logic                      chainReset,
	input  wire logic                      busStyleSelect,
	input  wire logic                      addressLatchStrobe,
	input  wire logic                      dataStrobe,
	input  wire logic                      readWrite,
	input  wire logic                      chipSel_n,
	input  wire logic [7:0]                muxedLineBusIn,
	input  wire logic [3:0]                rateSelect,
	input  wire logic                      squareWaveEnable,
	output logic [7:0]                     muxedLineBusOut,
	output logic                           muxedLineBusOe_n,
	output logic                           squareWaveOut,
	output logic                           squareWaveOe_n,
	output logic                           periodicTick,
	output logic                           accessReady
);
	muxed_port_pkg::bus_pins_t   pinsS1_ff;
	muxed_port_pkg::bus_pins_t   pinsS2_ff;
	muxed_port_pkg::bus_pins_t   pinsPrev_ff;
	muxed_port_pkg::addr_latch_t latch_ff;
	logic [31:0]                 upCnt_ff;
	logic                        accessReady_ff;
	logic [7:0]                  mem_ff [MEM_BYTES];
	logic                        strobeStyle;
	logic                        asFall;
	logic                        asRise;
	logic                        readActive;
	logic                        writeEvent;
	logic                        selected;
	logic                        tapLevel;
	logic                        tick;

	// first stage feeds only the second
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pinsS1_ff   <= '0;
			pinsS2_ff   <= '0;
			pinsPrev_ff <= '0;
		end else if (clkEn) begin
			pinsS1_ff   <= '{addressLatchStrobe, dataStrobe, readWrite, chipSel_n, muxedLineBusIn};
			pinsS2_ff   <= pinsS1_ff;
			pinsPrev_ff <= pinsS2_ff;
		end
	end

	// open pin is pulled down outside, so low means separate strobes
	assign strobeStyle = busStyleSelect;
	assign asFall      = pinsPrev_ff.addrStb & ~pinsS2_ff.addrStb;
	assign asRise      = ~pinsPrev_ff.addrStb & pinsS2_ff.addrStb;
	// low supply forces chip select inactive
	assign selected    = accessReady_ff & ~pinsS2_ff.chipSel_n;

	// power-up hold-off; restarts whenever supply drops or oscillator stalls
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			upCnt_ff       <= 32'h00000000;
			accessReady_ff <= 1'b0;
		end else if (clkEn) begin
			if (!supplyValid || !oscRunning || chainReset) begin
				upCnt_ff       <= 32'h00000000;
				accessReady_ff <= 1'b0;
			end else if (upCnt_ff >= 32'(POWERUP_CYCLES - 1)) begin
				accessReady_ff <= 1'b1;
			end else begin
				upCnt_ff <= upCnt_ff + 32'h00000001;
			end
		end
	end

	// address latch: rising strobe clears regardless of select
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			latch_ff <= '{1'b0, 1'b0, muxed_port_pkg::ADDR_RESET};
		end else if (clkEn) begin
			if (!supplyValid) begin
				latch_ff.valid <= 1'b0;
			end else if (asRise) begin
				latch_ff.valid <= 1'b0;
			end else if (asFall) begin
				latch_ff.valid <= 1'b1;
				latch_ff.addr  <= pinsPrev_ff.muxedIn[6:0];
				latch_ff.bank  <= pinsPrev_ff.muxedIn[6];
			end
		end
	end

	// strobe style: read while strobe high with r/w high; separate: read strobe low
	always_comb begin
		if (strobeStyle) begin
			readActive = pinsS2_ff.dataStb & pinsS2_ff.rdWr;
			writeEvent = pinsPrev_ff.dataStb & ~pinsS2_ff.dataStb & ~pinsPrev_ff.rdWr;
		end else begin
			readActive = ~pinsS2_ff.dataStb;
			writeEvent = ~pinsPrev_ff.rdWr & pinsS2_ff.rdWr;
		end
	end

	// all 128 locations are plain storage here; clock registers live elsewhere
	always_ff @(posedge mclk) begin
		if (clkEn && writeEvent && selected && latch_ff.valid) begin
			mem_ff[latch_ff.addr] <= pinsPrev_ff.muxedIn;
		end
	end

	// data drive window; released when strobe ends
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			muxedLineBusOut  <= 8'h00;
			muxedLineBusOe_n <= 1'b1;
		end else if (clkEn) begin
			if (readActive && selected && latch_ff.valid && supplyValid) begin
				muxedLineBusOut  <= mem_ff[latch_ff.addr];
				muxedLineBusOe_n <= 1'b0;
			end else begin
				muxedLineBusOut  <= 8'h00;
				muxedLineBusOe_n <= 1'b1;
			end
		end
	end

	rate_divider u_div (
		.mclk         (mclk),
		.rst_n        (rst_n),
		.clkEn        (clkEn),
		.chainReset   (chainReset),
		.rateSelect   (rateSelect),
		.tapLevel     (tapLevel),
		.periodicTick (tick)
	);

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			squareWaveOut  <= 1'b0;
			squareWaveOe_n <= 1'b1;
			periodicTick   <= 1'b0;
			accessReady    <= 1'b0;
		end else if (clkEn) begin
			squareWaveOut  <= tapLevel & squareWaveEnable & supplyValid;
			squareWaveOe_n <= ~supplyValid;
			periodicTick   <= tick;
			accessReady    <= accessReady_ff;
		end
	end

	bus_float_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clkEn && !supplyValid |=> muxedLineBusOe_n && squareWaveOe_n)
		else $error("outputs driven while supply low");

	powerup_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
		$rose(accessReady_ff) |-> $past(upCnt_ff) >= 32'(POWERUP_CYCLES - 1))
		else $error("access enabled before hold-off elapsed");

	sqw_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clkEn && !squareWaveEnable |=> !squareWaveOut)
		else $error("square wave not gated off");

	addr_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clkEn && asRise |=> !latch_ff.valid)
		else $error("address not cleared on strobe rise");

	addr_capture_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clkEn && supplyValid && asFall |=> latch_ff.valid && latch_ff.addr == $past(pinsPrev_ff.muxedIn[6:0]))
		else $error("address not captured on strobe fall");

	read_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
		!muxedLineBusOe_n |-> $past(readActive) && $past(selected))
		else $error("bus driven outside a read");

	no_sel_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clkEn && pinsS2_ff.chipSel_n |=> muxedLineBusOe_n)
		else $error("drive without chip select");

	read_end_a: assert property (@(posedge mclk) disable iff (!rst_n)
		clkEn && strobeStyle && !pinsS2_ff.dataStb |=> muxedLineBusOe_n)
		else $error("bus not released after strobe");
endmodule
`default_nettype wire

// [rtl/muxed_port_pkg.sv]
// shared constants and carrier types for the multiplexed bus port
`default_nettype none
package muxed_port_pkg;
	localparam int          CLK_HZ         = 20_000_000;
	localparam int          POWERUP_MS     = 200;
	localparam int          POWERUP_CYCLES = CLK_HZ / 1000 * POWERUP_MS;
	// divider base rate: 32768 Hz reference, one tick per CLK_HZ/REF_HZ cycles
	localparam int          REF_HZ         = 32768;
	localparam int          PRESCALE       = CLK_HZ / REF_HZ;
	localparam int          DIV_STAGES     = 15;
	localparam int          TAP_COUNT      = 13;
	localparam int          MEM_BYTES      = 128;
	localparam int          CLOCK_REGS     = 14;
	localparam int          RAM_BYTES      = 114;
	localparam int          ADDR_W         = 7;
	localparam int          DATA_W         = 8;
	localparam logic [3:0]  RATE_NONE      = 4'h0;
	localparam logic [6:0]  ADDR_RESET     = 7'h00;
	localparam logic [14:0] DIV_RESET      = 15'h0000;

	typedef struct packed {
		logic       addrStb;
		logic       dataStb;
		logic       rdWr;
		logic       chipSel_n;
		logic [7:0] muxedIn;
	} bus_pins_t;

	typedef struct packed {
		logic       valid;
		logic       bank;
		logic [6:0] addr;
	} addr_latch_t;
endpackage
`default_nettype wire

// [rtl/rate_divider.sv]
// divider chain and rate tap selection for square wave and periodic tick
`default_nettype none
module rate_divider #(
	parameter int PRESCALE = muxed_port_pkg::PRESCALE
) (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       clkEn,
	input  wire logic       chainReset,
	input  wire logic [3:0] rateSelect,
	output logic            tapLevel,
	output logic            periodicTick
);
	logic [15:0]                              preCnt_ff;
	logic [muxed_port_pkg::DIV_STAGES-1:0]    chain_ff;
	logic                                     tapLevel_ff;
	logic                                     nxt_tap;
	logic [muxed_port_pkg::TAP_COUNT-1:0]     taps;
	logic                                     refTick;

	assign refTick = (preCnt_ff == 16'(PRESCALE - 1));

	// chain keeps running regardless of supply or bus state
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			preCnt_ff <= 16'h0000;
			chain_ff  <= muxed_port_pkg::DIV_RESET;
		end else if (clkEn) begin
			if (chainReset) begin
				preCnt_ff <= 16'h0000;
				chain_ff  <= muxed_port_pkg::DIV_RESET;
			end else if (refTick) begin
				preCnt_ff <= 16'h0000;
				chain_ff  <= chain_ff + 15'h0001;
			end else begin
				preCnt_ff <= preCnt_ff + 16'h0001;
			end
		end
	end

	// tap i toggles at 8192 Hz >> i; chain bit 1 is 8192 Hz
	genvar i;
	generate
		for (i = 0; i < muxed_port_pkg::TAP_COUNT; i++) begin : g_tap
			assign taps[i] = chain_ff[i + 1];
		end
	endgenerate

	always_comb begin
		case (rateSelect)
			4'h0:    nxt_tap = 1'b0;
			4'h1:    nxt_tap = taps[5];
			4'h2:    nxt_tap = taps[6];
			4'h8:    nxt_tap = taps[5];
			4'h9:    nxt_tap = taps[6];
			default: nxt_tap = taps[rateSelect - 4'h3];
		endcase
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tapLevel_ff  <= 1'b0;
			periodicTick <= 1'b0;
		end else if (clkEn) begin
			tapLevel_ff  <= nxt_tap;
			periodicTick <= nxt_tap & ~tapLevel_ff & (rateSelect != muxed_port_pkg::RATE_NONE);
		end
	end

	assign tapLevel = tapLevel_ff;
endmodule
`default_nettype wire
